/* File: smb_pkg.sv */
// shared types and constants for the static memory byte-lane controller
package smb_pkg;
  localparam int unsigned NUM_CS = 6;
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CNT_W = 8;
  localparam logic [0:0] WIDTH_8 = 1'h0;
  localparam logic [0:0] WIDTH_16 = 1'h1;
  localparam logic [0:0] BAT_SELECT = 1'h0;
  localparam logic [0:0] BAT_WRITE = 1'h1;
  localparam logic [5:0] SLOW_SETUP = 6'h00;
  localparam logic [6:0] SLOW_PULSE = 7'h01;
  localparam logic [7:0] SLOW_CYCLE = 8'h01;
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic [3:0] TDF_RESET = 4'h0;
  localparam logic [5:0] CS_N_IDLE = 6'h3f;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam logic [2:0] CS_BOOT = 3'h0;
  localparam logic [4:0] PAGE_LOW_4 = 5'h03;

  typedef struct packed {
    logic [0:0] bus_width_field;
    logic [0:0] byte_access_type_bit;
    logic page_en;
    logic [1:0] page_size;
    logic [5:0] rd_setup;
    logic [6:0] rd_pulse;
    logic [7:0] rd_cycle;
    logic [5:0] wr_setup;
    logic [6:0] wr_pulse;
    logic [7:0] wr_cycle;
    logic [3:0] float_time;
  } smb_cfg_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [2:0] cs;
    logic [ADDR_W-1:0] addr;
    logic half;
    logic [DATA_W-1:0] wdata;
  } smb_req_t;

  typedef enum logic [1:0] {
    SMB_IDLE = 2'b00,
    SMB_ACCESS = 2'b01,
    SMB_FLOAT = 2'b10
  } smb_state_t;

  typedef struct packed {
    smb_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] last;
    logic [5:0] setup;
    logic [6:0] pulse;
    logic [3:0] tdf;
    logic [3:0] tdf_cnt;
    logic we;
    logic wide;
    logic bsel;
    logic lo;
    logic hi;
    logic [2:0] cs;
    logic [ADDR_W-1:0] addr;
    logic pg_valid;
    logic [2:0] pg_cs;
    logic [ADDR_W-1:0] pg_addr;
    logic [5:0] cs_n;
    logic rd_n;
    logic wr_n;
    logic a0_lbs_n;
    logic up_n;
    logic [ADDR_W-2:0] addr_o;
    logic [DATA_W-1:0] dout;
    logic doe;
    logic [DATA_W-1:0] rdata;
    logic done;
    logic busy;
  } smb_regs_t;
endpackage

/* File: smb_ctrl.sv */
// static memory controller: chip selects, byte lanes, timing, wait, slow clock and page reads
// Functional notes
// (RL1) six active-low chip selects, 24-bit address, 16 megabyte window each
// (RL2) small devices alias across their window; upper address lines pass unchanged
// (RL3) 8-bit uses address bits 23..0; 16-bit uses bits 23..1
// (RL4) data width 8 or 16 chosen per chip select
// (RL5) 16-bit chip select uses byte-write or byte-select, per chip select bit
// (RL6) byte-write: separate lower and upper write strobes, one shared read strobe
// (RL7) boot chip select never runs in byte-write; treated as byte-select (code forces byte-select only while i_boot_active is high)
// (RL8) byte-select: two byte selects, one read strobe, one write strobe
// (RL9) low wait request holds the strobe pulse and extends the access
// (RL10) slow clock mode replaces programmed waveforms with fixed slow ones
// (RL11) page-mode reads inside a 4 to 32 byte page skip setup
// (RL12) read setup, pulse and cycle programmable per chip select
// (RL13) write setup, pulse, cycle and data float time per chip select
// (RL14) address bit 0 shares lower select pin; upper write shares upper select
// (RL15) software disables controller before gating its clock off
// (RL16) 16-bit leaves A0 unused; each lane mode leaves the other pins unused
// (RL17) unused byte select and byte write pins held high
`timescale 1ns/10ps
module smb_ctrl (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire smb_pkg::smb_cfg_t [smb_pkg::NUM_CS-1:0] i_cfg,
  input wire smb_pkg::smb_req_t i_req,
  input wire logic i_slow_clk_mode,
  input wire logic i_boot_active,
  input wire logic i_wait_request_n,
  input wire logic [smb_pkg::DATA_W-1:0] i_data_in,
  output logic [smb_pkg::NUM_CS-1:0] o_chip_select_n,
  output logic o_read_strobe_n,
  output logic o_write_strobe_n,
  output logic o_lower_byte_sel_n,
  output logic o_upper_byte_n,
  output logic [smb_pkg::ADDR_W-2:0] o_addr,
  output logic [smb_pkg::DATA_W-1:0] o_data_out,
  output logic o_data_oe,
  output logic [smb_pkg::DATA_W-1:0] o_rdata,
  output logic o_done,
  output logic o_busy
);
  smb_pkg::smb_regs_t s_reg;
  smb_pkg::smb_regs_t s_next;

  // strobe is active in the pulse phase
  function automatic logic in_pulse(input logic [7:0] cnt, input logic [5:0] setup,
                                    input logic [6:0] pulse);
    logic [8:0] lo_b;
    logic [8:0] hi_b;
    lo_b = {3'h0, setup};
    hi_b = {3'h0, setup} + {2'h0, pulse};
    in_pulse = ({1'h0, cnt} >= lo_b) && ({1'h0, cnt} < hi_b);
  endfunction

  // page base mask for 4, 8, 16 or 32 byte pages
  function automatic logic [23:0] page_base(input logic [23:0] a, input logic [1:0] sz);
    logic [4:0] m;
    // each size step clears one more low bit, five of them for 32-byte pages
    m = ~(~smb_pkg::PAGE_LOW_4 << sz);
    page_base = a & ~{19'h0, m};
  endfunction

  // last strobe cycle: read data is taken here and wait may hold it
  function automatic logic last_pulse(input logic [7:0] cnt, input logic [5:0] setup,
                                      input logic [6:0] pulse);
    logic [8:0] end_b;
    end_b = {3'h0, setup} + {2'h0, pulse} - 9'h001;
    last_pulse = ({1'h0, cnt} == end_b);
  endfunction

  smb_pkg::smb_cfg_t c;
  logic [5:0] n_setup;
  logic [6:0] n_pulse;
  logic [7:0] n_cycle;
  logic [8:0] sp_end;
  logic [7:0] sp_last;
  logic page_hit;
  logic strobe;
  logic lane_lo;
  logic lane_hi;

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    c = i_cfg[i_req.cs];
    n_setup = i_req.we ? c.wr_setup : c.rd_setup; // RL12 RL13
    n_pulse = i_req.we ? c.wr_pulse : c.rd_pulse; // RL12 RL13
    n_cycle = i_req.we ? c.wr_cycle : c.rd_cycle; // RL12 RL13
    page_hit = c.page_en && !i_req.we && s_reg.pg_valid && (s_reg.pg_cs == i_req.cs) &&
               (page_base(i_req.addr, c.page_size) == page_base(s_reg.pg_addr, c.page_size));
    if (page_hit) begin
      n_setup = 6'h00; // RL11
    end
    if (i_slow_clk_mode) begin
      n_setup = smb_pkg::SLOW_SETUP; // RL10
      n_pulse = smb_pkg::SLOW_PULSE; // RL10
      n_cycle = smb_pkg::SLOW_CYCLE; // RL10
    end
    sp_end = {3'h0, n_setup} + {2'h0, n_pulse};
    sp_last = (n_cycle > sp_end[7:0]) ? n_cycle - 8'h01 : sp_end[7:0] - 8'h01;
    lane_lo = 1'b0;
    lane_hi = 1'b0;
    strobe = 1'b0;
    case (s_reg.st)
      smb_pkg::SMB_IDLE: begin
        if (i_req.req) begin
          s_next.st = smb_pkg::SMB_ACCESS;
          s_next.cnt = smb_pkg::CNT_RESET;
          s_next.last = sp_last;
          s_next.setup = n_setup;
          s_next.pulse = n_pulse;
          s_next.tdf = i_req.we ? smb_pkg::TDF_RESET : c.float_time; // RL13
          s_next.we = i_req.we;
          s_next.cs = i_req.cs;
          s_next.addr = i_req.addr;
          s_next.wide = (c.bus_width_field == smb_pkg::WIDTH_16); // RL4
          s_next.bsel = (c.byte_access_type_bit == smb_pkg::BAT_SELECT) ||
                        (i_boot_active && i_req.cs == smb_pkg::CS_BOOT); // RL5 RL7
          lane_lo = i_req.half || !i_req.addr[0];
          lane_hi = i_req.half || i_req.addr[0];
          s_next.lo = lane_lo;
          s_next.hi = lane_hi;
          s_next.dout = s_next.wide ? (i_req.half ? i_req.wdata :
                        (i_req.addr[0] ? {i_req.wdata[7:0], 8'h00} : i_req.wdata)) :
                        i_req.wdata;
          s_next.busy = 1'b1;
        end
      end
      smb_pkg::SMB_ACCESS: begin
        strobe = in_pulse(s_reg.cnt, s_reg.setup, s_reg.pulse);
        // wait is honoured only in the last pulse cycle, so the strobe stays low
        if (strobe && !i_wait_request_n && last_pulse(s_reg.cnt, s_reg.setup, s_reg.pulse)) begin
          s_next.cnt = s_reg.cnt; // RL9
        end else begin
          if (last_pulse(s_reg.cnt, s_reg.setup, s_reg.pulse) && !s_reg.we) begin
            s_next.rdata = (s_reg.wide && s_reg.hi && !s_reg.lo) ?
                           {8'h00, i_data_in[15:8]} : i_data_in;
          end
          if (s_reg.cnt == s_reg.last) begin
            s_next.done = 1'b1;
            s_next.pg_valid = !s_reg.we;
            s_next.pg_cs = s_reg.cs;
            s_next.pg_addr = s_reg.addr;
            s_next.tdf_cnt = s_reg.tdf;
            s_next.st = (s_reg.tdf == smb_pkg::TDF_RESET) ? smb_pkg::SMB_IDLE :
                        smb_pkg::SMB_FLOAT; // RL13
            s_next.busy = (s_reg.tdf != smb_pkg::TDF_RESET);
          end else begin
            s_next.cnt = s_reg.cnt + 8'h01;
          end
        end
      end
      smb_pkg::SMB_FLOAT: begin
        // bus stays idle after a read before another device may drive it
        s_next.tdf_cnt = s_reg.tdf_cnt - 4'h1;
        if (s_reg.tdf_cnt == 4'h1) begin
          s_next.st = smb_pkg::SMB_IDLE;
          s_next.busy = 1'b0;
        end
      end
      default: begin
        s_next.st = smb_pkg::SMB_IDLE;
        s_next.busy = 1'b0;
      end
    endcase

    // pin values follow the next state so every pin comes from a flop
    s_next.cs_n = smb_pkg::CS_N_IDLE;
    s_next.rd_n = 1'b1;
    s_next.wr_n = 1'b1;
    s_next.a0_lbs_n = 1'b1;
    s_next.up_n = 1'b1; // RL17
    s_next.doe = 1'b0;
    if (s_next.st == smb_pkg::SMB_ACCESS) begin
      strobe = in_pulse(s_next.cnt, s_next.setup, s_next.pulse);
      s_next.cs_n[s_next.cs] = 1'b0; // RL1
      s_next.addr_o = s_next.addr[23:1]; // RL2 RL3
      s_next.doe = s_next.we;
      s_next.rd_n = !(strobe && !s_next.we); // RL6 RL8
      if (!s_next.wide) begin
        s_next.a0_lbs_n = s_next.addr[0]; // RL3 RL14
        s_next.wr_n = !(strobe && s_next.we);
      end else if (s_next.bsel) begin
        s_next.a0_lbs_n = !s_next.lo; // RL8 RL14 RL16
        s_next.up_n = !s_next.hi; // RL8 RL14
        s_next.wr_n = !(strobe && s_next.we); // RL8
      end else begin
        s_next.wr_n = !(strobe && s_next.we && s_next.lo); // RL6 RL16
        s_next.up_n = !(strobe && s_next.we && s_next.hi); // RL6 RL14
      end
    end
  end

  // reset loads idle pin levels so no strobe glitches out of reset
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_reg <= '0;
      s_reg.st <= smb_pkg::SMB_IDLE;
      s_reg.cs_n <= smb_pkg::CS_N_IDLE;
      s_reg.rd_n <= 1'b1;
      s_reg.wr_n <= 1'b1;
      s_reg.a0_lbs_n <= 1'b1;
      s_reg.up_n <= 1'b1;
      s_reg.dout <= smb_pkg::DATA_RESET;
      s_reg.rdata <= smb_pkg::DATA_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_chip_select_n = s_reg.cs_n;
  assign o_read_strobe_n = s_reg.rd_n;
  assign o_write_strobe_n = s_reg.wr_n;
  assign o_lower_byte_sel_n = s_reg.a0_lbs_n;
  assign o_upper_byte_n = s_reg.up_n;
  assign o_addr = s_reg.addr_o;
  assign o_data_out = s_reg.dout;
  assign o_data_oe = s_reg.doe;
  assign o_rdata = s_reg.rdata;
  assign o_done = s_reg.done;
  assign o_busy = s_reg.busy;
endmodule

/* File: smb_mem_model.sv */
// behavioural static memory that answers reads and can stretch them
`timescale 1ns/10ps
module smb_mem_model (
  input wire logic i_sys_clk,
  input wire logic [5:0] i_cs_n,
  input wire logic i_rd_n,
  input wire logic [22:0] i_addr,
  input wire logic [3:0] i_stall,
  output logic [15:0] o_data,
  output logic o_wait_n
);
  logic [15:0] last_reg = 16'h0000;
  logic [3:0] wcnt_reg = 4'h0;
  logic sel;
  assign sel = !(&i_cs_n) && !i_rd_n;
  // released or stalled bus shows the inverse of the last value
  assign o_data = (sel && o_wait_n) ? (i_addr[15:0] ^ 16'ha5c3) : ~last_reg;
  assign o_wait_n = !(sel && wcnt_reg < i_stall);
  always_ff @(posedge i_sys_clk) begin
    if (sel && o_wait_n) begin
      last_reg <= o_data;
    end
    wcnt_reg <= sel ? wcnt_reg + ((wcnt_reg < i_stall) ? 4'h1 : 4'h0) : 4'h0;
  end
endmodule

/* File: smb_ctrl_sva.sv */
// assertions on the pins of the static memory controller
`timescale 1ns/10ps
module smb_ctrl_sva (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire smb_pkg::smb_req_t i_req,
  input wire logic i_slow_clk_mode,
  input wire logic i_wait_request_n,
  input wire logic [5:0] o_chip_select_n,
  input wire logic o_read_strobe_n,
  input wire logic o_write_strobe_n,
  input wire logic o_upper_byte_n,
  input wire logic [22:0] o_addr,
  input wire logic o_data_oe,
  input wire logic o_done,
  input wire logic o_busy
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  logic take;
  assign take = i_req.req && !o_busy;
  sequence s_slow_rd;
    !o_read_strobe_n ##[1:8] o_done;
  endsequence
  AST_CS_ONE: assert property ($onehot0(~o_chip_select_n))
    else $error("two chip selects low");
  AST_CS_DEC: assert property (take |=> o_chip_select_n == ~(6'h01 << $past(i_req.cs)))
    else $error("wrong chip select");
  AST_ADDR: assert property (take |=> o_addr == $past(i_req.addr[23:1]))
    else $error("address not passed");
  AST_RW_EXCL: assert property (!(!o_read_strobe_n && !o_write_strobe_n))
    else $error("read and write strobes together");
  AST_STB_CS: assert property ((!o_read_strobe_n || !o_write_strobe_n) |-> !(&o_chip_select_n))
    else $error("strobe without chip select");
  AST_OE_WR: assert property (o_data_oe |-> o_read_strobe_n)
    else $error("drive during read");
  AST_IDLE: assert property (&o_chip_select_n |-> o_read_strobe_n && o_write_strobe_n && o_upper_byte_n)
    else $error("lane pin low while idle");
  AST_DONE_1: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
  AST_WAIT: assert property (!o_read_strobe_n && !i_wait_request_n |=> !o_read_strobe_n)
    else $error("strobe released during wait");
  AST_SLOW: assert property (take && i_slow_clk_mode && !i_req.we |=> s_slow_rd)
    else $error("slow read waveform wrong");
  AST_BUSY: assert property (take |=> o_busy)
    else $error("busy missing after request");
endmodule
bind smb_ctrl smb_ctrl_sva u_sva (.i_sys_clk, .i_nrst, .i_req, .i_slow_clk_mode,
  .i_wait_request_n, .o_chip_select_n, .o_read_strobe_n, .o_write_strobe_n, .o_upper_byte_n,
  .o_addr, .o_data_oe, .o_done, .o_busy);

/* File: testbench.sv */
// self-checking bench for the static memory byte-lane controller
`timescale 1ns/10ps
module testbench;
  logic i_sys_clk = 1'b0;
  logic i_nrst = 1'b0;
  smb_pkg::smb_cfg_t [5:0] cfg;
  smb_pkg::smb_req_t req = '0;
  logic slow = 1'b0;
  logic boot = 1'b0;
  logic [3:0] stall = 4'h0;
  logic wait_n, rd_n, wr_n, lbs_n, ub_n, oe, done, busy;
  logic [5:0] cs_n, csv;
  logic [22:0] addr;
  logic [15:0] din, dout, rdata, dq, ex;
  logic [3:0] pins;
  int mismatches = 0;
  int n_checks = 0;
  int lat;
  smb_ctrl dut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_cfg(cfg), .i_req(req),
    .i_slow_clk_mode(slow), .i_boot_active(boot), .i_wait_request_n(wait_n),
    .i_data_in(din), .o_chip_select_n(cs_n), .o_read_strobe_n(rd_n),
    .o_write_strobe_n(wr_n), .o_lower_byte_sel_n(lbs_n), .o_upper_byte_n(ub_n),
    .o_addr(addr), .o_data_out(dout), .o_data_oe(oe), .o_rdata(rdata), .o_done(done),
    .o_busy(busy));
  smb_mem_model mem (.i_sys_clk(i_sys_clk), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_addr(addr),
    .i_stall(stall), .o_data(din), .o_wait_n(wait_n));
  function automatic smb_pkg::smb_cfg_t mk(logic [2:0] m, logic [15:0] t);
    mk = '{m[2], m[1], m[0], 2'h0, 6'(t[15:12]), 7'(t[11:8]), 8'(t[7:4]),
      6'(t[15:12]), 7'(t[11:8]), 8'(t[7:4]), t[3:0]};
  endfunction
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    if (mismatches == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic acc(logic we, logic [2:0] cs, logic [23:0] a, logic h, logic [15:0] wd,
      int el, logic [3:0] ep);
    @(negedge i_sys_clk);
    req = '{1'b1, we, cs, a, h, wd};
    ex = a[16:1] ^ 16'ha5c3;
    @(negedge i_sys_clk);
    req.req = 1'b0;
    lat = 1;
    pins = 4'hf;
    csv = 6'h3f;
    while (done !== 1'b1 && lat < 40) begin
      pins &= {lbs_n, ub_n, wr_n, rd_n};
      csv &= cs_n;
      if (oe === 1'b1) dq = dout;
      @(negedge i_sys_clk);
      lat++;
    end
    chk(lat, el);
    chk(pins, ep);
    chk(csv ^ 6'h3f, 6'h01 << cs);
  endtask
  initial forever #5 i_sys_clk = ~i_sys_clk;
  initial begin
    #20000;
    mismatches++;
    close_out;
  end
  initial begin
    cfg[0] = mk(3'h6, 16'h1240);
    cfg[1] = mk(3'h0, 16'h1240);
    cfg[2] = mk(3'h4, 16'h1240);
    cfg[3] = mk(3'h6, 16'h1240);
    cfg[4] = mk(3'h5, 16'h3240);
    cfg[5] = mk(3'h0, 16'h0112);
    repeat (2) @(posedge i_sys_clk);
    @(negedge i_sys_clk) i_nrst = 1'b1;
    acc(1'h0, 3'h1, 24'hfff123, 1'h0, 16'h0, 5, 4'he);
    chk(rdata[7:0], ex[7:0]);
    acc(1'h1, 3'h1, 24'h000200, 1'h0, 16'h0034, 5, 4'h5);
    chk(dq[7:0], 8'h34);
    acc(1'h1, 3'h2, 24'h000401, 1'h0, 16'h00b7, 5, 4'h9);
    chk(dq[15:8], 8'hb7);
    acc(1'h0, 3'h2, 24'h000402, 1'h1, 16'h0, 5, 4'h2);
    chk(rdata, ex);
    acc(1'h1, 3'h3, 24'h000600, 1'h0, 16'h0011, 5, 4'hd);
    acc(1'h1, 3'h3, 24'h000601, 1'h0, 16'h0022, 5, 4'hb);
    acc(1'h0, 3'h3, 24'h000603, 1'h0, 16'h0, 5, 4'he);
    chk(rdata[7:0], ex[15:8]);
    boot = 1'h1;
    acc(1'h1, 3'h0, 24'h000001, 1'h0, 16'h0055, 5, 4'h9);
    boot = 1'h0;
    acc(1'h1, 3'h0, 24'h000001, 1'h0, 16'h0055, 5, 4'hb);
    acc(1'h0, 3'h4, 24'h000800, 1'h1, 16'h0, 6, 4'h2);
    acc(1'h0, 3'h4, 24'h000802, 1'h1, 16'h0, 5, 4'h2);
    chk(rdata, ex);
    acc(1'h0, 3'h4, 24'h000810, 1'h1, 16'h0, 6, 4'h2);
    cfg[4].page_size = 2'h3;
    acc(1'h0, 3'h4, 24'h00081e, 1'h1, 16'h0, 5, 4'h2);
    chk(rdata, ex);
    slow = 1'h1;
    acc(1'h0, 3'h4, 24'h000900, 1'h1, 16'h0, 2, 4'h2);
    slow = 1'h0;
    stall = 4'h3;
    acc(1'h0, 3'h5, 24'h000a00, 1'h0, 16'h0, 5, 4'h6);
    chk(rdata, ex);
    stall = 4'h0;
    chk(busy, 1'h1);
    @(negedge i_sys_clk);
    chk(busy, 1'h1);
    @(negedge i_sys_clk);
    chk(busy, 1'h0);
    chk(cs_n, 6'h3f);
    close_out;
  end
endmodule
